//--- hdl/sleep_ctl_defs.vh
// Constants for the deep sleep and doze control block.
// Included by the block's single design file; holds definitions only.
`ifndef SLEEP_CTL_DEFS_VH
`define SLEEP_CTL_DEFS_VH
// Register byte offsets on APB
`define OFS_RESET_CTRL 12'h000
`define OFS_DS_CTRL 12'h004
`define OFS_DS_WAKE 12'h008
`define OFS_CLK_DIV 12'h00C
// Reset control register fields
`define BIT_SLEEP_EXIT 10
`define BIT_POR_FLAG 0
// Deep sleep control fields
`define BIT_DS_ARM 15
`define BIT_LP_BOR 1
`define BIT_PIN_HOLD 0
// Wake source fields
`define BIT_W_EXTERNAL_IRQ_ZERO 8
`define BIT_W_FLT 7
`define BIT_W_WDT 4
`define BIT_W_RTC 3
`define BIT_W_MASTER_RESET_PIN 2
`define BIT_W_POR 0
`define WAKE_MASK 16'h019D
// Clock divider fields
`define BIT_ROI 15
`define DOZE_HI 14
`define DOZE_LO 12
`define BIT_DOZE_EN 11
`define DOZE_RESET 3'h0
// Exit power-on sequence start count; exit_seq_busy stays high 17 cycles
`define EXIT_SEQ_CYCLES 8'h10
// Power-save instruction operand that selects sleep
`define PWRSAV_SLEEP 8'h00
`endif

//--- hdl/deep_sleep_doze_control.v
// Deep sleep arming, sleep-exit status, wake source capture and doze
// clock gating. Assumes an APB master on pclk and that the CPU
// reports each power-save instruction as a one-cycle strobe.
// Summary of operation
// - Sleep-exit flag sets on deep sleep entry, stays until software clears
// - True power-on reset resets all logic including deep sleep registers
// - Arm bit clears automatically when deep sleep exits on wake-up
// - Arm bit 15: power-save #0 enters deep sleep if set, else sleep
// - Bit 1 records brown-out seen by deep sleep detector, else zero
// - Deep sleep brown-out is status only, never a wake-up
// - Bit 0 set holds pins and oscillator in their deep sleep state
// - Control bits reset only by power-on outside deep sleep
// - Brown-out and hold bits reset 0 at first power-on; hold is 1 after exit
// - Wake bit 8 records external interrupt 0 during deep sleep
// - Wake bit 7 records a fault during deep sleep
// - Wake bit 4 records deep sleep watchdog time-out
// - Wake bit 3 records real-time clock alarm during deep sleep
// - Wake bit 2 records master reset pin assertion during deep sleep
// - Wake bit 0 records power-on detection, also outside deep sleep
// - Other wake flags set by hardware only during deep sleep
// - Doze enable bit 11 slows CPU clock, peripherals full speed
// - Doze ratio bits 14:12 pick 1:1 to 1:128, default 1:1
// - Return-on-interrupt bit 15 makes an interrupt restore full speed
// - CPU and peripheral clocks stay in step during doze
// - Wake events during exit sequence are ignored, not recorded
// - Reset pin wake keeps registers valid and hold bit set
// - Interrupts pending at deep sleep entry are cleared
//
// The register addresses and register access over APB are this design's own decisions.
`timescale 1ns/1ps
`include "sleep_ctl_defs.vh"
module deep_sleep_doze_control (
	// Clock and true power-on reset
	input wire pclk,
	input wire presetn,
	// APB slave
	input wire psel,
	input wire penable,
	input wire pwrite,
	input wire [11:0] paddr,
	input wire [31:0] pwdata,
	input wire [3:0] pstrb,
	output wire [31:0] prdata,
	output wire pready,
	output wire pslverr,
	// CPU power-save request
	input wire pwrsav_strobe,
	input wire [7:0] pwrsav_operand,
	input wire irq_event,
	// Wake and status sources
	input wire ext_irq0_event,
	input wire fault_event,
	input wire watchdog_timeout,
	input wire rtc_alarm,
	input wire master_reset_pin_n,
	input wire power_on_detect,
	input wire brownout_detect,
	input wire brownout_det_enable,
	// Power state outputs
	output reg in_deep_sleep,
	output reg in_sleep,
	output reg exit_seq_busy,
	output reg pin_hold,
	output reg io_reset,
	output reg clear_pending_irq,
	output reg cpu_clk_en,
	output reg periph_clk_en
);
	// Sequencer states. The exit state stands in for the power-on
	// sequence that follows a deep sleep wake, so events seen there
	// are dropped rather than recorded.
	localparam ST_RUN = 2'h0;
	localparam ST_DEEP = 2'h1;
	localparam ST_EXIT = 2'h2;

	reg [1:0] state_q;
	reg [7:0] exit_cnt_q;
	reg exit_by_master_reset_pin_q;
	reg sleep_exit_q;
	reg por_flag_q;
	reg ds_arm_q;
	reg lp_bor_q;
	reg [15:0] wake_q;
	reg roi_q;
	reg [2:0] doze_ratio_q;
	reg doze_en_q;
	reg [6:0] doze_cnt_q;
	reg [31:0] rdata_q;

	wire wr = psel & penable & pwrite;
	wire rd = psel & ~penable & ~pwrite;
	wire lo_lane = pstrb[0];
	wire hi_lane = pstrb[1];
	wire wake_any;
	wire doze_active;
	wire [6:0] doze_limit;
	wire deep_entry;
	// Writable wake bits; the rest always read back zero
	wire [15:0] wake_mask = `WAKE_MASK;

	// Address decode used by both read and write paths
	function is_reg;
		input [11:0] a;
		input [11:0] ofs;
		begin
			is_reg = (a == ofs);
		end
	endfunction

	// Doze ratio code to terminal count of the CPU enable divider.
	// Code n gives one CPU enable in every 2^n pclk cycles.
	function [6:0] ratio_to_limit;
		input [2:0] r;
		begin
			ratio_to_limit = (7'h01 << r) - 7'h01;
		end
	endfunction

	// Zero wait-state slave; unmapped addresses read zero, error on pslverr
	assign pready = 1'b1;
	assign pslverr = psel & penable & ~(is_reg(paddr, `OFS_RESET_CTRL) |
		is_reg(paddr, `OFS_DS_CTRL) | is_reg(paddr, `OFS_DS_WAKE) |
		is_reg(paddr, `OFS_CLK_DIV));
	assign prdata = rdata_q;

	// Brown-out never counts as wake; only listed sources leave deep sleep
	assign wake_any = ext_irq0_event | watchdog_timeout | rtc_alarm |
		~master_reset_pin_n | power_on_detect;
	assign deep_entry = (state_q == ST_RUN) & pwrsav_strobe &
		(pwrsav_operand == `PWRSAV_SLEEP) & ds_arm_q;

	// Power state sequencer
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state_q <= ST_RUN;
			exit_cnt_q <= 8'h00;
			exit_by_master_reset_pin_q <= 1'b0;
			in_deep_sleep <= 1'b0;
			in_sleep <= 1'b0;
			exit_seq_busy <= 1'b0;
			io_reset <= 1'b0;
			clear_pending_irq <= 1'b0;
		end else begin
			clear_pending_irq <= 1'b0;
			io_reset <= 1'b0;
			case (state_q)
			ST_RUN: begin
				// Power-save #0 goes deep only when armed beforehand;
				// otherwise it is a normal sleep that any interrupt
				// ends. Other operands are not ours to act on.
				if (deep_entry) begin
					state_q <= ST_DEEP;
					in_deep_sleep <= 1'b1;
					clear_pending_irq <= 1'b1;
				end else if (pwrsav_strobe &&
					pwrsav_operand == `PWRSAV_SLEEP) begin
					in_sleep <= 1'b1;
				end else if (in_sleep && irq_event) begin
					in_sleep <= 1'b0;
				end
			end
			ST_DEEP: begin
				// Any listed source starts the exit sequence. A reset
				// pin wake also pulses the pin reset, while hold stays
				// set so pins keep their sleep state until released.
				if (wake_any) begin
					state_q <= ST_EXIT;
					in_deep_sleep <= 1'b0;
					exit_seq_busy <= 1'b1;
					exit_cnt_q <= `EXIT_SEQ_CYCLES;
					exit_by_master_reset_pin_q <= ~master_reset_pin_n;
					io_reset <= ~master_reset_pin_n;
				end
			end
			ST_EXIT: begin
				// Exit behaves as a power-on; events here are dropped
				if (exit_cnt_q == 8'h00) begin
					state_q <= ST_RUN;
					exit_seq_busy <= 1'b0;
				end else begin
					exit_cnt_q <= exit_cnt_q - 8'h01;
				end
			end
			default: begin
				state_q <= ST_RUN;
			end
			endcase
		end
	end

	// Reset control flags; hardware set wins over software clear.
	// Sleep-exit together with power-on tells software that the last
	// reset was a deep sleep wake, not a true power-up.
	// Set statements come last so that a same-cycle clear loses.
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			sleep_exit_q <= 1'b0;
			por_flag_q <= 1'b1;
		end else begin
			if (wr && is_reg(paddr, `OFS_RESET_CTRL) && hi_lane)
				sleep_exit_q <= pwdata[`BIT_SLEEP_EXIT];
			if (wr && is_reg(paddr, `OFS_RESET_CTRL) && lo_lane)
				por_flag_q <= pwdata[`BIT_POR_FLAG];
			if (deep_entry)
				sleep_exit_q <= 1'b1;
			if (state_q == ST_DEEP && wake_any)
				por_flag_q <= 1'b1;
		end
	end

	// Deep sleep control; only a true power-on reaches presetn.
	// A wake is not wired to presetn, so brown-out survives it; arm clears, hold sets.
	// Hold is clear-only from software: writing one does nothing,
	// which stops firmware from freezing pins by accident.
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ds_arm_q <= 1'b0;
			lp_bor_q <= 1'b0;
			pin_hold <= 1'b0;
		end else begin
			if (wr && is_reg(paddr, `OFS_DS_CTRL) && hi_lane)
				ds_arm_q <= pwdata[`BIT_DS_ARM];
			if (wr && is_reg(paddr, `OFS_DS_CTRL) && lo_lane) begin
				lp_bor_q <= pwdata[`BIT_LP_BOR];
				if (!pwdata[`BIT_PIN_HOLD])
					pin_hold <= 1'b0;
			end
			if (state_q == ST_DEEP && brownout_det_enable && brownout_detect)
				lp_bor_q <= 1'b1;
			if (deep_entry)
				pin_hold <= 1'b1;
			if (state_q == ST_DEEP && wake_any) begin
				ds_arm_q <= 1'b0;
				pin_hold <= 1'b1;
				if (exit_by_master_reset_pin_q)
					pin_hold <= 1'b1;
			end
		end
	end

	// Wake source capture, gated to deep sleep except power-on.
	// Software writes only reach implemented bits; hardware sets
	// follow the write so an event in the same cycle is kept.
	// Power-on may be flagged in run, but never during exit.
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			wake_q <= 16'h0000;
		end else begin
			if (wr && is_reg(paddr, `OFS_DS_WAKE)) begin
				if (lo_lane)
					wake_q[7:0] <= pwdata[7:0] & wake_mask[7:0];
				if (hi_lane)
					wake_q[15:8] <= pwdata[15:8] & wake_mask[15:8];
			end
			if (state_q == ST_DEEP) begin
				if (ext_irq0_event)
					wake_q[`BIT_W_EXTERNAL_IRQ_ZERO] <= 1'b1;
				if (fault_event)
					wake_q[`BIT_W_FLT] <= 1'b1;
				if (watchdog_timeout)
					wake_q[`BIT_W_WDT] <= 1'b1;
				if (rtc_alarm)
					wake_q[`BIT_W_RTC] <= 1'b1;
				if (!master_reset_pin_n)
					wake_q[`BIT_W_MASTER_RESET_PIN] <= 1'b1;
			end
			if (power_on_detect && state_q != ST_EXIT)
				wake_q[`BIT_W_POR] <= 1'b1;
		end
	end

	// Clock divider controls.
	// With return-on-interrupt set, an interrupt drops doze enable,
	// so software must set it again to slow the CPU once more.
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			roi_q <= 1'b0;
			doze_ratio_q <= `DOZE_RESET;
			doze_en_q <= 1'b0;
		end else begin
			if (wr && is_reg(paddr, `OFS_CLK_DIV) && hi_lane) begin
				roi_q <= pwdata[`BIT_ROI];
				doze_ratio_q <= pwdata[`DOZE_HI:`DOZE_LO];
				doze_en_q <= pwdata[`BIT_DOZE_EN];
			end
			if (roi_q && irq_event)
				doze_en_q <= 1'b0;
		end
	end

	assign doze_active = doze_en_q & ~in_deep_sleep;
	assign doze_limit = ratio_to_limit(doze_ratio_q);

	// CPU enable pulses on one edge of the shared clock, so both stay aligned.
	// Gating by enables rather than a divided clock keeps one clock
	// tree, at the cost of a free-running pclk in every mode.
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			doze_cnt_q <= 7'h00;
			cpu_clk_en <= 1'b1;
			periph_clk_en <= 1'b1;
		end else begin
			periph_clk_en <= ~in_deep_sleep;
			if (!doze_active || doze_cnt_q >= doze_limit) begin
				doze_cnt_q <= 7'h00;
				cpu_clk_en <= ~in_deep_sleep & ~in_sleep;
			end else begin
				doze_cnt_q <= doze_cnt_q + 7'h01;
				cpu_clk_en <= 1'b0;
			end
		end
	end

	// Read data registered in setup cycle, valid at access edge.
	// Taking it one cycle early keeps prdata off a combinational mux
	// and still allows a zero wait-state access phase.
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			rdata_q <= 32'h00000000;
		end else if (rd) begin
			rdata_q <= 32'h00000000;
			if (is_reg(paddr, `OFS_RESET_CTRL)) begin
				rdata_q[`BIT_SLEEP_EXIT] <= sleep_exit_q;
				rdata_q[`BIT_POR_FLAG] <= por_flag_q;
			end
			if (is_reg(paddr, `OFS_DS_CTRL)) begin
				rdata_q[`BIT_DS_ARM] <= ds_arm_q;
				rdata_q[`BIT_LP_BOR] <= lp_bor_q;
				rdata_q[`BIT_PIN_HOLD] <= pin_hold;
			end
			if (is_reg(paddr, `OFS_DS_WAKE))
				rdata_q[15:0] <= wake_q & `WAKE_MASK;
			if (is_reg(paddr, `OFS_CLK_DIV)) begin
				rdata_q[`BIT_ROI] <= roi_q;
				rdata_q[`DOZE_HI:`DOZE_LO] <= doze_ratio_q;
				rdata_q[`BIT_DOZE_EN] <= doze_en_q;
			end
		end
	end

endmodule

//--- bench/wake_source_model.sv
// Model of the wake-up event sources that sit beside the block.
// Assumes the bench raises a request mask for one pclk cycle.
`timescale 1ns/1ps
module wake_source_model (
	// Clock and request
	input wire pclk,
	input wire [5:0] mask,
	// Event lines to the block
	output wire ext_irq0_event,
	output wire fault_event,
	output wire watchdog_timeout,
	output wire rtc_alarm,
	output wire master_reset_pin_n,
	output wire power_on_detect
);
	logic [5:0] e_q = 6'h00;

	// Real sources pulse once, so each request is one event cycle
	always @(posedge pclk) begin
		e_q <= mask;
	end
	assign ext_irq0_event = e_q[0];
	assign fault_event = e_q[1];
	assign watchdog_timeout = e_q[2];
	assign rtc_alarm = e_q[3];
	assign master_reset_pin_n = ~e_q[4]; // Pin idles high
	assign power_on_detect = e_q[5];
endmodule

//--- bench/sleep_ctl_monitor.sv
// Checker for the deep sleep and doze control block.
// Sees only the block's ports; bound to every instance below.
`timescale 1ns/1ps
module sleep_ctl_monitor (
	// Clock and reset
	input wire pclk,
	input wire presetn,
	// CPU and wake inputs
	input wire pwrsav_strobe,
	input wire [7:0] pwrsav_operand,
	input wire ext_irq0_event,
	input wire watchdog_timeout,
	input wire rtc_alarm,
	input wire master_reset_pin_n,
	input wire power_on_detect,
	input wire brownout_detect,
	// Power state outputs
	input wire in_deep_sleep,
	input wire exit_seq_busy,
	input wire pin_hold,
	input wire io_reset,
	input wire clear_pending_irq
);
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	// Any genuine wake-up request this cycle
	wire wake_any = ext_irq0_event | watchdog_timeout | rtc_alarm |
		~master_reset_pin_n | power_on_detect;

	a_entry_cause: assert property (
		$rose(in_deep_sleep) |-> $past(pwrsav_strobe) &&
		$past(pwrsav_operand) == 8'h00) else $error("Bad entry");
	a_irq_flush: assert property (
		$rose(in_deep_sleep) |-> clear_pending_irq) else $error("No flush");
	a_flush_only: assert property (
		clear_pending_irq |-> $rose(in_deep_sleep)) else $error("Odd flush");
	a_hold_entry: assert property (
		$rose(in_deep_sleep) |-> pin_hold) else $error("Hold not set");
	a_bor_nowake: assert property (
		in_deep_sleep && brownout_detect && !wake_any |=> in_deep_sleep)
		else $error("Brown-out woke device");
	a_exit_len: assert property (
		$rose(exit_seq_busy) |-> ##16 exit_seq_busy ##1 !exit_seq_busy)
		else $error("Exit length wrong");
	a_exit_hold: assert property (
		$rose(exit_seq_busy) |-> !in_deep_sleep && pin_hold)
		else $error("Exit state wrong");
	a_pin_wake: assert property (
		in_deep_sleep && !master_reset_pin_n |=> io_reset && pin_hold)
		else $error("Reset pin wake wrong");
endmodule

bind deep_sleep_doze_control sleep_ctl_monitor i_mon (.pclk, .presetn,
	.pwrsav_strobe, .pwrsav_operand, .ext_irq0_event, .watchdog_timeout,
	.rtc_alarm, .master_reset_pin_n, .power_on_detect, .brownout_detect,
	.in_deep_sleep, .exit_seq_busy, .pin_hold, .io_reset,
	.clear_pending_irq);

//--- bench/tb_top.sv
// Testbench for the deep sleep and doze control block.
// Assumes the wake source model and the bound checker.
`timescale 1ns/1ps
module tb_top;
	logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
	logic pws = 0, irq = 0, bor = 0, boren = 0, er;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0, prdata, rd;
	logic [7:0] op = 8'h00;
	logic [5:0] fm = 6'h00;
	logic pready, pslverr, external_irq_zero, flt, wdt, rtc, mrn, pod;
	logic ids, isl, busy, hold, cpuen, pen;
	int fail_count = 0, total_checks = 0, n, p, i;
	logic [15:0] wb [6] = '{16'h0100, 16'h0080, 16'h0010, 16'h0008,
		16'h0004, 16'h0001};

	// Free-running 100 MHz clock
	always #5 pclk = ~pclk;

	deep_sleep_doze_control i_dut (.pclk, .presetn, .psel, .penable,
		.pwrite, .paddr, .pwdata, .pstrb(4'hF), .prdata, .pready, .pslverr,
		.pwrsav_strobe(pws), .pwrsav_operand(op), .irq_event(irq),
		.ext_irq0_event(external_irq_zero), .fault_event(flt), .watchdog_timeout(wdt),
		.rtc_alarm(rtc), .master_reset_pin_n(mrn), .power_on_detect(pod),
		.brownout_detect(bor), .brownout_det_enable(boren),
		.in_deep_sleep(ids), .in_sleep(isl), .exit_seq_busy(busy),
		.pin_hold(hold), .io_reset(), .clear_pending_irq(),
		.cpu_clk_en(cpuen), .periph_clk_en(pen));
	wake_source_model i_src (.pclk, .mask(fm), .ext_irq0_event(external_irq_zero),
		.fault_event(flt), .watchdog_timeout(wdt), .rtc_alarm(rtc),
		.master_reset_pin_n(mrn), .power_on_detect(pod));

	task stop_test;
		$display("checks %0d errors %0d", total_checks, fail_count);
		if (fail_count == 0 && total_checks > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask
	task chk(input logic [31:0] got, input logic [31:0] exp);
		total_checks++;
		if (got !== exp) begin
			fail_count++;
			$display("ERROR %0t got %h want %h", $time, got, exp);
		end
	endtask
	// APB transfer; holds the request until pready is sampled high
	task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		@(posedge pclk);
		psel <= 1;
		penable <= 0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1;
		do @(posedge pclk); while (pready !== 1'b1);
		rd = prdata;
		er = pslverr;
		psel <= 0;
		penable <= 0;
	endtask
	task save(input logic [7:0] o);
		@(posedge pclk);
		pws <= 1;
		op <= o;
		@(posedge pclk);
		pws <= 0;
		#1;
	endtask
	task kick;
		@(posedge pclk);
		irq <= 1;
		@(posedge pclk);
		irq <= 0;
		#1;
	endtask
	task ev(input logic [5:0] m);
		@(posedge pclk);
		fm <= m;
		@(posedge pclk);
		fm <= 6'h00;
	endtask
	task cnt(input int c);
		n = 0;
		p = 0;
		// Skip the enable launched under the old settings
		@(posedge pclk);
		repeat (c) begin
			@(posedge pclk);
			n += cpuen;
			p += pen;
		end
	endtask

	// Main sequence
	initial begin
		repeat (2) @(posedge pclk);
		presetn <= 1;
		apb(0, 12'h000, 0);
		chk(rd, 32'h1);
		apb(0, 12'h004, 0);
		chk(rd, 32'h0);
		apb(0, 12'h00C, 0);
		chk(rd, 32'h0);
		apb(0, 12'h010, 0);
		chk({rd[30:0], er}, 32'h1);
		apb(1, 12'h008, 32'hFFFF);
		apb(0, 12'h008, 0);
		chk(rd, 32'h019D);
		apb(1, 12'h008, 0);
		ev(6'h21);
		apb(0, 12'h008, 0);
		chk(rd, 32'h0001);
		apb(1, 12'h008, 0);
		save(8'h00);
		chk({ids, isl}, 2'b01);
		kick;
		chk(isl, 1'b0);
		// Deep sleep once per wake source, fault riding on the first
		for (i = 0; i < 6; i++) if (i != 1) begin
			boren <= i[0];
			apb(1, 12'h004, 32'h8000);
			save(8'h00);
			chk(ids, 1'b1);
			@(posedge pclk) bor <= 1;
			@(posedge pclk) bor <= 0;
			#1 chk(ids, 1'b1);
			ev((6'h01 << i) | (i ? 6'h00 : 6'h02));
			n = 0;
			while (busy !== 1'b1 && n < 9) begin
				@(posedge pclk);
				n++;
			end
			ev(6'h08);
			while (busy !== 1'b0 && n < 40) begin
				@(posedge pclk);
				n++;
			end
			apb(0, 12'h008, 0);
			chk(rd, wb[i] | (i ? 16'h0 : 16'h0080));
			apb(0, 12'h004, 0);
			chk(rd, {boren, 1'b1});
			apb(0, 12'h000, 0);
			chk(rd, 32'h0401);
			apb(1, 12'h000, 0);
			apb(1, 12'h004, 0);
			apb(1, 12'h008, 0);
			apb(0, 12'h004, 0);
			chk({rd[1:0], hold}, 3'h0);
		end
		// Every doze ratio, then interrupts with and without return
		for (i = 0; i < 8; i++) begin
			apb(1, 12'h00C, 32'h0800 | (i << 12));
			cnt(128);
			chk(n, 128 >> i);
			chk(p, 128);
		end
		apb(1, 12'h00C, 32'hB800);
		kick;
		cnt(16);
		chk(n, 16);
		apb(1, 12'h00C, 32'h3800);
		kick;
		cnt(16);
		chk(n, 2);
		stop_test;
	end

	// Watchdog against a hang
	initial begin
		#300000;
		fail_count++;
		stop_test;
	end
endmodule
